/* hw/pirc_ctrl.v */
// priority interrupt controller: control/status registers, arbiter and entry/return sequencer
//
// Operation
// R1: return pops PC and status byte, cycles 1-2
// R2: return cycle 3 fetch as nop, 4 resumes
// R3: entry latency same for one/two-cycle instructions
// R4: special cases add exactly one entry cycle
// R5: flag set by source, cleared by software
// R6: per-source enable bit gates its flag
// R7: per-source three-bit priority, eight levels
// R8: sources map to bits in vector order
// R9: cpu priority field in status bits 7:5
// R10: level 7 masks all user interrupts
// R11: core bit 3 forms fourth priority bit
// R12: fourth priority bit only readable or clearable
// R13: nesting disable bit 15, freezes priority field
// R14: trap cause flags in bits 6:1
// R15: bit 15 selects alternate vector table
// R16: bit 14 shows timed mask active
// R17: bits 4:0 select external edge polarity
// R18: unimplemented bits ignore writes, read zero
// R19: request presented only above cpu priority
// R20: entry loads accepted priority into field
// R21: nesting disabled forces field to 7
// R22: ties resolved by lowest vector number
`timescale 1ns/1ps
`include "pirc_consts.vh"

module pirc_ctrl (
    input wire clk_i,
    input wire rst_b_i,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // request sources
    input wire [15:0] periph_irq_i,
    input wire [4:0] ext_irq_i,
    input wire [5:0] trap_set_i,
    // processor core side
    input wire trap_enter_i,
    input wire timed_mask_instr_active_i,
    input wire extra_latency_i,
    input wire return_from_interrupt_instr_i,
    input wire [7:0] pop_status_low_byte_i,
    input wire pop_priority_level_top_bit_i,
    output wire irq_pending_o,
    output wire irq_ack_o,
    output reg [3:0] ack_vector_o,
    output wire ctx_save_o,
    output wire vec_fetch_o,
    output wire isr_fetch_o,
    output wire ret_pop_o,
    output wire ret_nop_o,
    output wire ret_resume_o,
    output wire [7:0] status_low_byte_o,
    output wire priority_level_top_bit_o,
    output wire alternate_table_select_o,
    output wire program_space_visibility_o
);

// ----------------------------------------
// sequencer states
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_STALL = 4'h1;
localparam [3:0] ST_SAVE = 4'h2;
localparam [3:0] ST_VEC = 4'h3;
localparam [3:0] ST_ISR = 4'h4;
localparam [3:0] ST_RPOP1 = 4'h5;
localparam [3:0] ST_RPOP2 = 4'h6;
localparam [3:0] ST_RNOP = 4'h7;
localparam [3:0] ST_RRES = 4'h8;

// ----------------------------------------
// registers and signals
// ----------------------------------------
reg [2:0] cpu_priority_field;
reg priority_level_top_bit;
reg [3:0] status_low;
reg pspace_vis;
reg nesting_disable;
reg [5:0] trap_flags;
reg alt_table;
reg [4:0] edge_pol;
reg [15:0] request_flag_reg_zero;
reg [15:0] source_enable_reg_zero;
reg [47:0] source_priority_regs;
reg [4:0] ext_s1;
reg [4:0] ext_s2;
reg [4:0] ext_d;
reg [3:0] state;
reg [3:0] next_state;
reg [2:0] acc_level;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg [3:0] best_id;
reg [2:0] best_lvl;
reg found;
reg [2:0] lvl;
reg [31:0] rd_word;
reg rd_hit;
integer i;
integer j;
integer m;

wire wr_fire = aw_held && w_held && !s_axi_bvalid;
wire [4:0] ext_edge;
wire [15:0] set_vec;
wire prio_wr;
wire [1:0] prio_idx;
wire [1:0] rd_idx;
wire [15:0] merged;

// ----------------------------------------
// byte-lane merge of a 16-bit register
// ----------------------------------------
function [15:0] lane_merge;
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    begin
        lane_merge[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
        lane_merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    end
endfunction

// priority word index, wraps so the first priority word is index 0
function [1:0] prio_index;
    input [7:0] addr;
    reg [2:0] sum;
    begin
        sum = {1'b0, addr[3:2]} + 3'h2;
        prio_index = sum[1:0];
    end
endfunction

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
assign s_axi_awready = !aw_held;
assign s_axi_wready = !w_held;

// hold address and data until both are present, then answer
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PIRC_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= `PIRC_OFS_PRIO3) ?
                `PIRC_RESP_OKAY : `PIRC_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
assign s_axi_arready = !s_axi_rvalid;
assign rd_idx = prio_index(s_axi_araddr);

// register read mux, unimplemented bits read zero
always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
        `PIRC_OFS_STATUS: rd_word[7:0] = {cpu_priority_field, 1'b0, status_low}; // [R9] [R18]
        `PIRC_OFS_CORE: begin
            rd_word[`PIRC_CORE_TOPBIT] = priority_level_top_bit; // [R11]
            rd_word[`PIRC_CORE_PSPACE] = pspace_vis;
        end
        `PIRC_OFS_NEST_TRAP: begin
            rd_word[`PIRC_NT_NEST] = nesting_disable;
            rd_word[6:1] = trap_flags; // [R14]
        end
        `PIRC_OFS_VEC_EDGE: begin
            rd_word[`PIRC_VE_ALT] = alt_table;
            rd_word[`PIRC_VE_TMASK] = timed_mask_instr_active_i; // [R16]
            rd_word[4:0] = edge_pol;
        end
        `PIRC_OFS_FLAG0: rd_word[15:0] = request_flag_reg_zero;
        `PIRC_OFS_ENABLE0: rd_word[15:0] = source_enable_reg_zero;
        default: begin
            if (s_axi_araddr >= `PIRC_OFS_PRIO0 && s_axi_araddr <= `PIRC_OFS_PRIO3 &&
                s_axi_araddr[1:0] == 2'h0) begin
                // four sources per word, one nibble each [R8]
                for (j = 0; j < 4; j = j + 1)
                    rd_word[4*j +: 3] = source_priority_regs[3*(4*rd_idx + j) +: 3];
            end else begin
                rd_hit = 1'b0;
            end
        end
    endcase
end

// one-cycle read answer
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PIRC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `PIRC_RESP_OKAY : `PIRC_RESP_DECERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------
// external pin sync and edge detect
// ----------------------------------------
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        ext_s1 <= 5'h00;
        ext_s2 <= 5'h00;
        ext_d <= 5'h00;
    end else begin
        ext_s1 <= ext_irq_i;
        ext_s2 <= ext_s1;
        ext_d <= ext_s2;
    end
end

// polarity 1 picks falling edge, 0 rising edge
assign ext_edge = (edge_pol & ext_d & ~ext_s2) | (~edge_pol & ~ext_d & ext_s2); // [R17]
assign set_vec = periph_irq_i | {11'h000, ext_edge}; // [R5] [R8]

// ----------------------------------------
// priority arbiter
// ----------------------------------------
// scan from the top so the lowest index wins a tie
always @* begin
    best_id = 4'h0;
    best_lvl = 3'h0;
    found = 1'b0;
    lvl = 3'h0;
    for (i = 15; i >= 0; i = i - 1) begin
        lvl = source_priority_regs[3*i +: 3]; // [R7]
        if (request_flag_reg_zero[i] && source_enable_reg_zero[i] && // [R6]
            !(timed_mask_instr_active_i && lvl != `PIRC_LVL_MAX) &&
            lvl >= best_lvl) begin // [R22]
            best_id = i[3:0];
            best_lvl = lvl;
            found = 1'b1;
        end
    end
end

// level 7 field leaves nothing strictly above it
assign irq_pending_o = found && ({1'b0, best_lvl} >
    {priority_level_top_bit, cpu_priority_field}); // [R19] [R10] [R11]

// ----------------------------------------
// entry and return sequencer
// ----------------------------------------
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (return_from_interrupt_instr_i)
                next_state = ST_RPOP1;
            else if (irq_pending_o)
                next_state = extra_latency_i ? ST_STALL : ST_SAVE; // [R3] [R4]
        end
        ST_STALL: next_state = ST_SAVE; // [R4]
        ST_SAVE: next_state = ST_VEC;
        ST_VEC: next_state = ST_ISR;
        ST_ISR: next_state = ST_IDLE;
        ST_RPOP1: next_state = ST_RPOP2; // [R1]
        ST_RPOP2: next_state = ST_RNOP;
        ST_RNOP: next_state = ST_RRES; // [R2]
        ST_RRES: next_state = ST_IDLE;
        default: next_state = ST_IDLE;
    endcase
end

// state and accepted request latch
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        state <= ST_IDLE;
        acc_level <= 3'h0;
        ack_vector_o <= 4'h0;
    end else begin
        state <= next_state;
        if (state == ST_IDLE && !return_from_interrupt_instr_i && irq_pending_o) begin
            acc_level <= best_lvl;
            ack_vector_o <= best_id;
        end
    end
end

assign irq_ack_o = (state == ST_SAVE);
assign ctx_save_o = (state == ST_SAVE);
assign vec_fetch_o = (state == ST_VEC);
assign isr_fetch_o = (state == ST_ISR);
assign ret_pop_o = (state == ST_RPOP1) || (state == ST_RPOP2); // [R1]
assign ret_nop_o = (state == ST_RNOP); // [R2]
assign ret_resume_o = (state == ST_RRES); // [R2]
assign status_low_byte_o = {cpu_priority_field, 1'b0, status_low};
assign priority_level_top_bit_o = priority_level_top_bit;
assign alternate_table_select_o = alt_table; // [R15]
assign program_space_visibility_o = pspace_vis;

// ----------------------------------------
// control and status registers
// ----------------------------------------
assign prio_wr = wr_fire && aw_addr >= `PIRC_OFS_PRIO0 && aw_addr <= `PIRC_OFS_PRIO3 &&
    aw_addr[1:0] == 2'h0;
assign prio_idx = prio_index(aw_addr);
// flag word after the byte-lane merge of a software write
assign merged = lane_merge(request_flag_reg_zero, w_data, w_strb);

// software writes, hardware events win over them
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        cpu_priority_field <= 3'h0; // [R9]
        priority_level_top_bit <= 1'b0;
        status_low <= 4'h0;
        pspace_vis <= 1'b0;
        nesting_disable <= 1'b0;
        trap_flags <= 6'h00;
        alt_table <= 1'b0;
        edge_pol <= 5'h00;
        request_flag_reg_zero <= `PIRC_RST_WORD;
        source_enable_reg_zero <= `PIRC_RST_WORD;
        source_priority_regs <= 48'h0000_0000_0000;
    end else begin
        // status word: field frozen while nesting is off
        if (wr_fire && aw_addr == `PIRC_OFS_STATUS && w_strb[0]) begin
            status_low <= w_data[3:0];
            if (!nesting_disable)
                cpu_priority_field <= w_data[7:5]; // [R9] [R13]
        end
        // core word: top level bit may only be cleared
        if (wr_fire && aw_addr == `PIRC_OFS_CORE && w_strb[0]) begin
            pspace_vis <= w_data[`PIRC_CORE_PSPACE];
            if (!w_data[`PIRC_CORE_TOPBIT])
                priority_level_top_bit <= 1'b0; // [R12]
        end
        if (wr_fire && aw_addr == `PIRC_OFS_NEST_TRAP) begin
            if (w_strb[1])
                nesting_disable <= w_data[`PIRC_NT_NEST]; // [R13]
            if (w_strb[0])
                trap_flags <= w_data[6:1] | trap_set_i; // [R14]
            else
                trap_flags <= trap_flags | trap_set_i;
        end else begin
            trap_flags <= trap_flags | trap_set_i;
        end
        if (wr_fire && aw_addr == `PIRC_OFS_VEC_EDGE) begin
            if (w_strb[1])
                alt_table <= w_data[`PIRC_VE_ALT]; // [R15]
            if (w_strb[0])
                edge_pol <= w_data[4:0]; // [R17]
        end
        // flags: a set in the clearing cycle survives
        if (wr_fire && aw_addr == `PIRC_OFS_FLAG0) begin
            request_flag_reg_zero <= merged | set_vec; // [R5]
        end else begin
            request_flag_reg_zero <= request_flag_reg_zero | set_vec; // [R5]
        end
        if (wr_fire && aw_addr == `PIRC_OFS_ENABLE0)
            source_enable_reg_zero <= lane_merge(source_enable_reg_zero, w_data, w_strb);
        if (prio_wr) begin
            for (m = 0; m < 4; m = m + 1)
                if (w_strb[m / 2])
                    source_priority_regs[3*(4*prio_idx + m) +: 3] <= w_data[4*m +: 3]; // [R8]
        end
        // hardware updates of the priority level
        if (state == ST_SAVE)
            cpu_priority_field <= nesting_disable ? `PIRC_LVL_MAX : acc_level; // [R20] [R21]
        else if (state == ST_RPOP2) begin
            cpu_priority_field <= pop_status_low_byte_i[7:5]; // [R1]
            status_low <= pop_status_low_byte_i[3:0];
            priority_level_top_bit <= pop_priority_level_top_bit_i;
        end
        if (trap_enter_i)
            priority_level_top_bit <= 1'b1; // [R12]
    end
end

endmodule // pirc_ctrl

/* hw/pirc_consts.vh */
// constants for the priority interrupt control block
`ifndef PIRC_CONSTS_VH
`define PIRC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PIRC_OFS_STATUS 8'h00
`define PIRC_OFS_CORE 8'h04
`define PIRC_OFS_NEST_TRAP 8'h08
`define PIRC_OFS_VEC_EDGE 8'h0C
`define PIRC_OFS_FLAG0 8'h10
`define PIRC_OFS_ENABLE0 8'h14
`define PIRC_OFS_PRIO0 8'h18
`define PIRC_OFS_PRIO3 8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define PIRC_STAT_FIELD_LO 5
`define PIRC_CORE_TOPBIT 3
`define PIRC_CORE_PSPACE 2
`define PIRC_NT_NEST 15
`define PIRC_NT_TRAP_LO 1
`define PIRC_VE_ALT 15
`define PIRC_VE_TMASK 14

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PIRC_RST_WORD 16'h0000
`define PIRC_LVL_MAX 3'h7
`define PIRC_RESP_OKAY 2'h0
`define PIRC_RESP_DECERR 2'h3

`endif

/* testbench/pirc_ctrl_sva.sv */
// checker on the priority interrupt control ports
`timescale 1ns/1ps
module pirc_ctrl_sva (
    input wire clk_i,
    input wire rst_b_i,
    input wire trap_enter_i,
    input wire irq_pending_o,
    input wire irq_ack_o,
    input wire ctx_save_o,
    input wire vec_fetch_o,
    input wire isr_fetch_o,
    input wire ret_pop_o,
    input wire ret_nop_o,
    input wire ret_resume_o,
    input wire [7:0] status_low_byte_o,
    input wire priority_level_top_bit_o
);
    // ----
    // sequencer and level checks
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_ENTRY: assert property (irq_ack_o |-> ctx_save_o ##1 vec_fetch_o ##1 isr_fetch_o)
        else $error("entry strobes out of order");
    AST_ACK_ONE: assert property (irq_ack_o |=> !irq_ack_o)
        else $error("ack longer than one cycle");
    AST_RET: assert property ($rose(ret_pop_o) |->
        ret_pop_o[*2] ##1 ret_nop_o ##1 ret_resume_o) else $error("return cycles out of order");
    AST_LVL7: assert property (status_low_byte_o[7:5] == 3'h7 |-> !irq_pending_o)
        else $error("request shown at level seven");
    AST_TOP: assert property (priority_level_top_bit_o |-> !irq_pending_o)
        else $error("request shown above level seven");
    AST_TRAP: assert property (trap_enter_i |=> priority_level_top_bit_o)
        else $error("trap entry did not set top bit");
    AST_BIT4: assert property (status_low_byte_o[4] == 1'h0)
        else $error("unused status bit not zero");
    AST_RAISE: assert property (irq_ack_o |=>
        status_low_byte_o[7:5] > $past(status_low_byte_o[7:5])) else $error("level not raised");
endmodule // pirc_ctrl_sva

bind pirc_ctrl pirc_ctrl_sva pirc_ctrl_sva_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .trap_enter_i(trap_enter_i), .irq_pending_o(irq_pending_o), .irq_ack_o(irq_ack_o),
    .ctx_save_o(ctx_save_o), .vec_fetch_o(vec_fetch_o), .isr_fetch_o(isr_fetch_o),
    .ret_pop_o(ret_pop_o), .ret_nop_o(ret_nop_o), .ret_resume_o(ret_resume_o),
    .status_low_byte_o(status_low_byte_o),
    .priority_level_top_bit_o(priority_level_top_bit_o));

/* testbench/pirc_core_model.sv */
// core model: context stack and return requests
`timescale 1ns/1ps
module pirc_core_model (
    input wire clk_i,
    input wire rst_b_i,
    input wire ret_req_i,
    input wire ctx_save_i,
    input wire [7:0] status_low_byte_i,
    input wire top_bit_i,
    input wire ret_pop_i,
    output reg ret_instr_o,
    output reg [8:0] pop_o
);
    reg [8:0] stack [0:7];
    reg [2:0] sp;
    // push on save, pop on return, scramble pop data when unused
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp <= 3'h0;
            ret_instr_o <= 1'h0;
            pop_o <= 9'h000;
        end else begin
            ret_instr_o <= ret_req_i;
            if (ctx_save_i) begin
                stack[sp] <= {top_bit_i, status_low_byte_i};
                sp <= sp + 3'h1;
            end
            if (ret_req_i) begin
                pop_o <= stack[sp - 3'h1];
                sp <= sp - 3'h1;
            end else if (!ret_pop_i && !ret_instr_o) begin
                pop_o <= ~pop_o;
            end
        end
    end
endmodule // pirc_core_model

/* testbench/pirc_ctrl_tb.sv */
// self-checking bench for the priority interrupt control block
`timescale 1ns/1ps
`include "pirc_consts.vh"
module pirc_ctrl_tb;
    reg clk_i = 0, rst_b_i = 0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ret_req = 0;
    reg tent = 0, tmask = 0, xlat = 0, inseq = 0, ta, tw, tb;
    reg [7:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, rv;
    reg [15:0] pirq = 0, en, mdl [0:9];
    reg [4:0] eirq = 0;
    reg [5:0] tset = 0;
    reg [3:0] gvec = 0;
    reg [1:0] rr;
    wire awready, wready, bvalid, arready, rvalid, pend, ack, ctx, isf, rres, top, alt, rfi;
    wire pspace, rpop;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] avec;
    wire [7:0] slb;
    wire [8:0] pop;
    integer error_cnt = 0, checks_done = 0, lat = 0, acks = 0;
    integer i, k, n, c, f, nst, bl, best, a0, pr [0:15];

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    pirc_ctrl pirc_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_irq_i(pirq), .ext_irq_i(eirq), .trap_set_i(tset), .trap_enter_i(tent),
        .timed_mask_instr_active_i(tmask), .extra_latency_i(xlat),
        .return_from_interrupt_instr_i(rfi), .pop_status_low_byte_i(pop[7:0]),
        .pop_priority_level_top_bit_i(pop[8]), .irq_pending_o(pend), .irq_ack_o(ack),
        .ack_vector_o(avec), .ctx_save_o(ctx), .vec_fetch_o(), .isr_fetch_o(isf),
        .ret_pop_o(rpop), .ret_nop_o(), .ret_resume_o(rres), .status_low_byte_o(slb),
        .priority_level_top_bit_o(top), .alternate_table_select_o(alt),
        .program_space_visibility_o(pspace));

    pirc_core_model pirc_core_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ret_req_i(ret_req),
        .ctx_save_i(ctx), .status_low_byte_i(slb), .top_bit_i(top),
        .ret_pop_i(rpop), .ret_instr_o(rfi), .pop_o(pop));

    // ----
    // helpers
    // ----
    task automatic chk(input [31:0] e, input [31:0] g, input [63:0] nm);
        begin
            checks_done = checks_done + 1;
            if (e !== g) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task tmo(input ok);
        if (!ok) begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    endtask

    // axi write: hold each channel until its own ready edge
    task wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            tb = 0;
            for (n = 0; n < 50 && !tb; n = n + 1) begin
                @(negedge clk_i);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bvalid;
                rr = bresp;
                @(posedge clk_i);
                if (ta) awvalid <= 0;
                if (tw) wvalid <= 0;
            end
            tmo(tb);
        end
    endtask

    // axi read
    task rd(input [7:0] a);
        begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            tb = 0;
            for (n = 0; n < 50 && !tb; n = n + 1) begin
                @(negedge clk_i);
                ta = arvalid && arready;
                tb = rvalid;
                rv = rdata;
                rr = rresp;
                @(posedge clk_i);
                if (ta) arvalid <= 0;
            end
            tmo(tb);
        end
    endtask

    // register model update, then write
    task wreg(input [7:0] a, input [15:0] d);
        begin
            case (a)
                8'h00: mdl[0] = (d & 16'h000f) | ((mdl[2][15] ? mdl[0] : d) & 16'h00e0);
                8'h04: mdl[1] = (d & 16'h0004) | (mdl[1] & d & 16'h0008);
                8'h08: mdl[2] = d & 16'h807e;
                8'h0c: mdl[3] = d & 16'h801f;
                8'h10, 8'h14: mdl[a >> 2] = d;
                default: mdl[a >> 2] = d & 16'h7777;
            endcase
            wr(a, {16'h0000, d});
        end
    endtask

    task rchk(input [7:0] a);
        begin
            rd(a);
            chk({16'h0000, mdl[a >> 2]}, rv, "register");
        end
    endtask

    // entry latency and winner capture
    always @(posedge clk_i) begin
        if (ack) begin
            chk(1 + xlat, lat, "latency");
            gvec <= avec;
            acks <= acks + 1;
            inseq <= 1;
        end else if (isf) begin
            inseq <= 0;
        end
        lat <= (pend && !inseq && !ack) ? lat + 1 : 0;
    end

    // ----
    // main sequence
    // ----
    initial begin
        i = $urandom(99117);
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1;
        @(posedge clk_i);
        for (i = 0; i < 10; i = i + 1) begin
            mdl[i] = 0;
            rchk(8'(i * 4));
            wreg(8'(i * 4), 16'hffff);
            rchk(8'(i * 4));
        end
        chk(2'h3, {alt, pspace}, "alt_pspc");
        for (i = 9; i >= 0; i = i - 1) begin
            wreg(8'(i * 4), 16'h0000);
            rchk(8'(i * 4));
        end
        rd(8'h28);
        chk(`PIRC_RESP_DECERR, {rv[29:0], rr}, "unmapped");
        for (k = 0; k < 6; k = k + 1) begin
            tset <= 6'h01 << k;
            @(posedge clk_i);
            tset <= 6'h00;
            mdl[2] = 16'h0002 << k;
            rchk(8'h08);
            wreg(8'h08, 16'h0000);
        end
        tent <= 1;
        @(posedge clk_i);
        tent <= 0;
        mdl[1] = 16'h0008;
        rchk(8'h04);
        wreg(8'h04, 16'h0008);
        rchk(8'h04);
        wreg(8'h04, 16'h0000);
        rchk(8'h04);
        for (k = 0; k < 5; k = k + 1) begin
            f = $urandom % 2;
            wreg(8'h0c, 16'(f << k));
            eirq[k] <= f[0];
            repeat (6) @(posedge clk_i);
            wreg(8'h10, 16'h0000);
            eirq[k] <= !f[0];
            repeat (6) @(posedge clk_i);
            mdl[4] = 16'h0001 << k;
            rchk(8'h10);
            wreg(8'h10, 16'h0000);
            eirq[k] <= f[0];
            repeat (6) @(posedge clk_i);
            rchk(8'h10);
        end
        tmask <= 1;
        repeat (2) @(posedge clk_i);
        rd(8'h0c);
        chk({16'h0000, mdl[3] | 16'h4000}, rv, "tmask");
        tmask <= 0;
        for (k = 0; k < 10; k = k + 1) begin
            wreg(8'h08, 16'h0000);
            wreg(8'h00, 16'h00e0);
            for (i = 0; i < 16; i = i + 1)
                pr[i] = $urandom % 8;
            for (i = 0; i < 4; i = i + 1)
                wreg(8'h18 + 8'(i * 4), 16'(pr[4*i] | pr[4*i+1] << 4 | pr[4*i+2] << 8 | pr[4*i+3] << 12));
            rv = $urandom;
            en = $urandom;
            pirq <= rv[15:0];
            @(posedge clk_i);
            pirq <= 16'h0000;
            mdl[4] = mdl[4] | rv[15:0];
            rchk(8'h10);
            f = $urandom % 7;
            nst = $urandom % 2;
            xlat <= $urandom;
            wreg(8'h00, 16'(f << 5));
            wreg(8'h08, 16'(nst << 15));
            best = -1;
            bl = f;
            for (i = 0; i < 16; i = i + 1)
                if (mdl[4][i] && en[i] && pr[i] > bl) begin
                    best = i;
                    bl = pr[i];
                end
            a0 = acks;
            wreg(8'h14, en);
            if (best < 0) begin
                repeat (8) @(posedge clk_i);
                chk(a0, acks, "no_entry");
            end else begin
                for (c = 0; c < 50 && acks == a0; c = c + 1)
                    @(posedge clk_i);
                tmo(acks != a0);
                chk(best, gvec, "vector");
                mdl[0] = nst ? 16'h00e0 : 16'(bl << 5);
                rchk(8'h00);
                if (nst) begin
                    wreg(8'h00, 16'h0000);
                    rchk(8'h00);
                end
                wreg(8'h10, 16'h0000);
                ret_req <= 1;
                @(posedge clk_i);
                ret_req <= 0;
                for (c = 0; c < 50 && !rres; c = c + 1)
                    @(negedge clk_i);
                tmo(rres);
                @(posedge clk_i);
                mdl[0] = 16'(f << 5);
                rchk(8'h00);
            end
            wreg(8'h14, 16'h0000);
        end
        print_verdict;
    end
endmodule // pirc_ctrl_tb
